// ==== rtl/spb_regs.vh ====
`ifndef SPB_REGS_VH
`define SPB_REGS_VH
`define SPB_HASH_W     16
`define SPB_SERIAL_W   16
`define SPB_DEV_N      16
`define SPB_SETTLE_NS  1000
`define SPB_SETTLE_CYC ((`SPB_SETTLE_NS + 7) / 8)
`define SPB_ERR_NONE   4'h0
`define SPB_ERR_BAT    4'h1
`define SPB_ERR_PATH   4'h2
`define SPB_ERR_SERIAL 4'h3
`define SPB_ERR_HASH   4'h4
`define SPB_ERR_CONS   4'h5
`define SPB_ERR_POWER  4'h6
`define SPB_CMD_DATA   2'h0
`define SPB_CMD_HDR    2'h1
`define SPB_CMD_END    2'h2
`endif

// ==== rtl/spb_arbiter.v ====
`include "spb_regs.vh"
module spb_arbiter #(
  parameter N = `SPB_DEV_N
) (
  input  wire         clk,
  input  wire         reset_n,
  input  wire [N-1:0] req,
  input  wire         enable,
  output reg  [N-1:0] grant_r
);
  reg  [N-1:0] pick;
  reg          found;
  integer      i;
  // fixed priority, lowest index wins
  always @* begin
    pick  = {N{1'b0}};
    found = 1'b0;
    for (i = 0; i < N; i = i + 1) begin
      if (req[i] && !found) begin
        pick[i] = 1'b1;
        found   = 1'b1;
      end
    end
  end
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      grant_r <= {N{1'b0}};
    end else begin
      grant_r <= enable ? pick : {N{1'b0}};
    end
  end
endmodule

// ==== rtl/spb_sequencer.v ====
`include "spb_regs.vh"
module spb_sequencer #(
  parameter HW      = `SPB_HASH_W,
  parameter SW      = `SPB_SERIAL_W,
  parameter N       = `SPB_DEV_N,
  parameter SETTLE  = `SPB_SETTLE_CYC
) (
  input  wire          clk,
  input  wire          reset_n,
  input  wire          diskette_mounted,
  input  wire          load_button,
  input  wire          poweroff_button,
  input  wire          self_test_ok,
  input  wire          store_test_ok,
  input  wire          drive_ready,
  input  wire          path_ok,
  input  wire          console_ok,
  input  wire          power_good,
  input  wire          sp2_present,
  input  wire          expansion_fitted,
  input  wire [SW-1:0] machine_serial,
  input  wire          disk_valid,
  input  wire [1:0]    disk_kind,
  input  wire [7:0]    disk_byte,
  input  wire          cs_read,
  input  wire [31:0]   cs_word,
  input  wire          cs_parity,
  input  wire [7:0]    dec_bits,
  input  wire          dec_check,
  input  wire          machine_check,
  input  wire          channel_check,
  input  wire          logout_valid,
  input  wire          logout_last,
  input  wire          sp2_logout_valid,
  input  wire          diag_done,
  input  wire          patch_req,
  input  wire [N-1:0]  dev_req,
  input  wire          bus_grant,
  output reg           sp_power_r,
  output reg           drive_power_r,
  output reg           disk_read_r,
  output reg           disk_write_r,
  output reg  [7:0]    disk_wdata_r,
  output reg           load_own_r,
  output reg           load_ip_r,
  output reg           load_sp2_r,
  output reg           init_dls_r,
  output reg           sections_power_r,
  output reg           remote_power_r,
  output reg           ip_suspend_r,
  output reg           logout_req_r,
  output reg           mc_interrupt_r,
  output reg           sp2_logout_r,
  output reg           parity_err_r,
  output reg           decode_err_r,
  output reg           bus_req_r,
  output reg  [N-1:0]  dev_grant_r,
  output reg           busy_r,
  output reg           done_r,
  output reg  [3:0]    err_code_r
);
  localparam S_OFF    = 4'h0;
  localparam S_BAT    = 4'h1;
  localparam S_PATH   = 4'h2;
  localparam S_REC1   = 4'h3;
  localparam S_OWN    = 4'h4;
  localparam S_CONS   = 4'h5;
  localparam S_PWR    = 4'h6;
  localparam S_IPLOAD = 4'h7;
  localparam S_SP2    = 4'h8;
  localparam S_DLS    = 4'h9;
  localparam S_RUN    = 4'hA;
  localparam S_DIAG   = 4'hB;
  localparam S_PATCH  = 4'hC;
  localparam S_FAIL   = 4'hD;
  localparam CW       = 12;
  localparam [CW-1:0] SETTLE_C = SETTLE[CW-1:0];

  reg [3:0]    state_r;
  reg [3:0]    state_nxt;
  reg [CW-1:0] cnt_r;
  reg [HW-1:0] hash_r;
  reg [SW-1:0] serial_r;
  reg [1:0]    ser_idx_r;
  reg [1:0]    hsh_idx_r;
  reg [HW-1:0] want_r;
  reg          log_done_r;
  reg [2:0]    mnt_s;
  reg [2:0]    btn_s;
  reg [2:0]    off_s;
  reg [2:0]    mc_s;
  reg          btn_q;
  reg          off_q;
  reg [3:0]    err_nxt;
  wire         mounted  = mnt_s[1] & mnt_s[2];
  wire         btn_now  = (btn_s[1] == btn_s[2]) ? btn_s[2] : btn_q;
  wire         off_now  = (off_s[1] == off_s[2]) ? off_s[2] : off_q;
  wire         mc_now   = mc_s[1] & mc_s[2];
  wire         btn_rise = btn_now & ~btn_q;
  wire         off_rise = off_now & ~off_q;
  wire         settled  = (cnt_r >= SETTLE_C);
  wire         rec_end  = disk_valid && (disk_kind == `SPB_CMD_END);
  wire [N-1:0] dev_mask = expansion_fitted ? {N{1'b1}} : {{(N/2){1'b0}}, {(N/2){1'b1}}};
  wire [N-1:0] grants;
  wire         load_state = (state_r == S_OWN) || (state_r == S_IPLOAD) || (state_r == S_SP2);

  spb_arbiter #(.N(N)) u_arb (
    .clk     (clk),
    .reset_n (reset_n),
    .req     (dev_req & dev_mask),
    .enable  (state_r == S_RUN),
    .grant_r (grants)
  );

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mnt_s <= 3'h0;
      btn_s <= 3'h0;
      off_s <= 3'h0;
      mc_s  <= 3'h0;
      btn_q <= 1'b0;
      off_q <= 1'b0;
    end else begin
      mnt_s <= {mnt_s[1:0], diskette_mounted};
      btn_s <= {btn_s[1:0], load_button};
      off_s <= {off_s[1:0], poweroff_button};
      mc_s  <= {mc_s[1:0], machine_check | channel_check};
      btn_q <= btn_now;
      off_q <= off_now;
    end
  end

  always @* begin
    state_nxt = state_r;
    err_nxt   = `SPB_ERR_NONE;
    case (state_r)
      S_OFF:    if (mounted) state_nxt = S_BAT;
      S_BAT:    if (settled) begin
                  if (self_test_ok && store_test_ok) state_nxt = S_PATH;
                  else err_nxt = `SPB_ERR_BAT;
                end
      S_PATH:   if (settled) begin
                  if (drive_ready && path_ok) state_nxt = S_REC1;
                  else err_nxt = `SPB_ERR_PATH;
                end
      S_REC1:   if (rec_end) begin
                  if (serial_r == machine_serial) state_nxt = S_OWN;
                  else err_nxt = `SPB_ERR_SERIAL;
                end
      S_OWN:    if (rec_end) begin
                  if (hash_r == want_r) state_nxt = S_CONS;
                  else err_nxt = `SPB_ERR_HASH;
                end
      S_CONS:   if (settled) begin
                  if (console_ok) state_nxt = S_PWR;
                  else err_nxt = `SPB_ERR_CONS;
                end
      S_PWR:    if (settled) begin
                  if (power_good) state_nxt = S_IPLOAD;
                  else err_nxt = `SPB_ERR_POWER;
                end
      S_IPLOAD: if (rec_end) begin
                  if (hash_r != want_r) err_nxt = `SPB_ERR_HASH;
                  else if (sp2_present) state_nxt = S_SP2;
                  else state_nxt = S_DLS;
                end
      S_SP2:    if (rec_end) begin
                  if (hash_r == want_r) state_nxt = S_DLS;
                  else err_nxt = `SPB_ERR_HASH;
                end
      S_DLS:    if (settled) state_nxt = S_RUN;
      S_RUN:    if (mc_now) state_nxt = S_DIAG;
                else if (patch_req) state_nxt = S_PATCH;
                else if (btn_rise) state_nxt = S_BAT;
      S_DIAG:   if (log_done_r && diag_done && !mc_now) state_nxt = S_RUN;
      S_PATCH:  if (!patch_req) state_nxt = S_RUN;
      S_FAIL:   if (btn_rise && mounted) state_nxt = S_BAT;
      default:  state_nxt = S_OFF;
    endcase
    if (err_nxt != `SPB_ERR_NONE) state_nxt = S_FAIL;
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r    <= S_OFF;
      cnt_r      <= {CW{1'b0}};
      err_code_r <= `SPB_ERR_NONE;
      done_r     <= 1'b0;
      busy_r     <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r) cnt_r <= {CW{1'b0}};
      else if (!settled) cnt_r <= cnt_r + 1'b1;
      if (err_nxt != `SPB_ERR_NONE) err_code_r <= err_nxt;
      else if (state_nxt == S_BAT && state_r != S_BAT) err_code_r <= `SPB_ERR_NONE;
      done_r <= (state_nxt == S_RUN) || (state_nxt == S_DIAG) || (state_nxt == S_PATCH);
      busy_r <= (state_nxt != S_OFF) && (state_nxt != S_RUN) && (state_nxt != S_FAIL);
    end
  end

  // hash and serial fields come framed by header command bytes on the diskette
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hash_r    <= {HW{1'b0}};
      want_r    <= {HW{1'b0}};
      serial_r  <= {SW{1'b0}};
      ser_idx_r <= 2'h0;
      hsh_idx_r <= 2'h0;
    end else if (state_nxt != state_r) begin
      hash_r    <= {HW{1'b0}};
      hsh_idx_r <= 2'h0;
      ser_idx_r <= 2'h0;
    end else if (disk_valid) begin
      if (state_r == S_REC1 && disk_kind == `SPB_CMD_HDR && ser_idx_r < 2'h2) begin
        serial_r  <= {serial_r[SW-9:0], disk_byte};
        ser_idx_r <= ser_idx_r + 1'b1;
      end
      if (load_state && disk_kind == `SPB_CMD_DATA) begin
        hash_r <= hash_r + {{(HW-8){1'b0}}, disk_byte};
      end
      if (load_state && disk_kind == `SPB_CMD_HDR && hsh_idx_r < 2'h2) begin
        want_r    <= {want_r[HW-9:0], disk_byte};
        hsh_idx_r <= hsh_idx_r + 1'b1;
      end
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sp_power_r       <= 1'b0;
      drive_power_r    <= 1'b0;
      disk_read_r      <= 1'b0;
      disk_write_r     <= 1'b0;
      disk_wdata_r     <= 8'h00;
      load_own_r       <= 1'b0;
      load_ip_r        <= 1'b0;
      load_sp2_r       <= 1'b0;
      init_dls_r       <= 1'b0;
      sections_power_r <= 1'b0;
      remote_power_r   <= 1'b0;
      ip_suspend_r     <= 1'b0;
      logout_req_r     <= 1'b0;
      mc_interrupt_r   <= 1'b0;
      sp2_logout_r     <= 1'b0;
      log_done_r       <= 1'b0;
      parity_err_r     <= 1'b0;
      decode_err_r     <= 1'b0;
      bus_req_r        <= 1'b0;
      dev_grant_r      <= {N{1'b0}};
    end else begin
      sp_power_r    <= 1'b1;
      drive_power_r <= (state_nxt != S_OFF);
      // reads follow sequencer states only; the one program path to the drive is patch writes in S_PATCH
      disk_read_r   <= (state_nxt == S_REC1) || (state_nxt == S_OWN) ||
                       (state_nxt == S_IPLOAD) || (state_nxt == S_SP2);
      disk_write_r  <= (state_r == S_PATCH) && patch_req;
      disk_wdata_r  <= cs_word[7:0];
      load_own_r    <= (state_nxt == S_OWN);
      load_ip_r     <= (state_nxt == S_IPLOAD);
      load_sp2_r    <= (state_nxt == S_SP2);
      init_dls_r    <= (state_nxt == S_DLS);
      if (state_nxt == S_PWR) sections_power_r <= 1'b1;
      else if (off_rise || state_nxt == S_OFF) sections_power_r <= 1'b0;
      if (state_nxt == S_PWR) remote_power_r <= 1'b1;
      else if (off_rise) remote_power_r <= 1'b0;
      ip_suspend_r  <= (state_nxt == S_DIAG);
      logout_req_r  <= (state_nxt == S_DIAG) && !log_done_r;
      sp2_logout_r  <= (state_r == S_DIAG) && sp2_present && sp2_logout_valid;
      if (state_r != S_DIAG) log_done_r <= 1'b0;
      else if (logout_valid && logout_last) log_done_r <= 1'b1;
      // interrupt raised only on leaving diagnosis
      mc_interrupt_r <= (state_r == S_DIAG) && (state_nxt == S_RUN);
      if (cs_read && (^{cs_word, cs_parity})) parity_err_r <= 1'b1;
      else if (btn_rise) parity_err_r <= 1'b0;
      if (cs_read && (dec_check != ^dec_bits)) decode_err_r <= 1'b1;
      else if (btn_rise) decode_err_r <= 1'b0;
      if (|grants) bus_req_r <= 1'b1;
      else if (bus_grant) bus_req_r <= 1'b0;
      if (|grants) dev_grant_r <= grants;
      else if (bus_grant) dev_grant_r <= {N{1'b0}};
    end
  end
endmodule

// ==== verif/spb_seq_sva.sv ====
module spb_seq_sva #(
  parameter N = 16
) (
  input logic         clk,
  input logic         reset_n,
  input logic         sp2_present,
  input logic         expansion_fitted,
  input logic         sp_power_r,
  input logic         drive_power_r,
  input logic         load_own_r,
  input logic         load_ip_r,
  input logic         load_sp2_r,
  input logic         init_dls_r,
  input logic         sections_power_r,
  input logic         ip_suspend_r,
  input logic         logout_req_r,
  input logic         mc_interrupt_r,
  input logic [N-1:0] dev_grant_r,
  input logic         done_r,
  input logic [3:0]   err_code_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_OWN_PWR: assert property (load_own_r |-> sp_power_r && drive_power_r)
    else $error("own load without power");
  AST_IP_PWR: assert property (load_ip_r || load_sp2_r || init_dls_r |-> sections_power_r)
    else $error("load before sections power");
  AST_SP2: assert property (load_sp2_r |-> sp2_present)
    else $error("second controller load while absent");
  AST_ERR_STOP: assert property (err_code_r != 4'h0 |-> !(load_ip_r || init_dls_r || done_r))
    else $error("sequence went on after error");
  AST_MCI: assert property (mc_interrupt_r |-> $past(ip_suspend_r) ##1 !mc_interrupt_r)
    else $error("interrupt not after diagnosis");
  AST_LOGOUT: assert property (logout_req_r |-> ip_suspend_r)
    else $error("logout with processor running");
  AST_ONEHOT: assert property ($onehot0(dev_grant_r))
    else $error("more than one device granted");
  AST_DEV_LIM: assert property (|dev_grant_r[N-1:8] |-> expansion_fitted)
    else $error("upper device granted without feature");
endmodule
bind spb_sequencer spb_seq_sva #(.N(N)) u_sva (.*);

// ==== verif/spb_disk_model.sv ====
module spb_disk_model #(
  parameter logic [15:0] SERIAL = 16'h0000
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       drive_power_r,
  input  wire logic       disk_read_r,
  input  wire logic       loading,
  input  wire logic       bad_hash,
  output logic            drive_ready,
  output logic            disk_valid,
  output logic [1:0]      disk_kind,
  output logic [7:0]      disk_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] hdr;
  task put(input logic [1:0] k, input logic [7:0] b);
    disk_valid = 1;
    disk_kind = k;
    disk_byte = b;
    @(negedge clk);
    disk_valid = 0;
    disk_kind = ~k;
    disk_byte = ~b; // released lines must not keep the old byte
    @(negedge clk);
  endtask
  always @(negedge clk) drive_ready <= reset_n && drive_power_r;
  initial begin
    drive_ready = 0;
    disk_valid = 0;
    disk_kind = 0;
    disk_byte = 0;
    forever begin
      @(negedge clk);
      if (reset_n && disk_read_r) begin
        hdr = loading ? (bad_hash ? 16'h0115 : 16'h0114) : SERIAL;
        put(2'h1, hdr[15:8]);
        put(2'h1, hdr[7:0]);
        for (int i = 0; i < 4; i++) put(2'h0, 8'h12 + 8'h22 * 8'(i));
        put(2'h2, 8'h00);
        @(negedge clk);
      end
    end
  end
endmodule

// ==== verif/test_support_processor_boot_sequencer.sv ====
module test_support_processor_boot_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, reset_n = 0, load_button = 0, bad_hash = 0, expansion_fitted = 0;
  logic        cs_read = 0, cs_parity = 0, dec_check = 0, machine_check = 0, diag_done = 0;
  logic        channel_check = 0, logout_valid = 0, logout_last = 0, bus_grant = 0;
  logic [3:0]  okv = 4'hF;
  logic [7:0]  dec_bits = 8'h03;
  logic [15:0] machine_serial = 16'hA5C3, dev_req = 16'h0000;
  logic [31:0] cs_word = 32'h1;
  logic        poweroff_button = 0, sp2_logout_valid = 0, patch_req = 0;
  wire         diskette_mounted = 1'b1, sp2_present = 1'b1;
  wire         self_test_ok = okv[0];
  wire         store_test_ok = okv[0], path_ok = okv[1], console_ok = okv[2];
  wire         power_good = okv[3], drive_ready, disk_valid, disk_write_r, busy_r;
  wire         done_r, sp2_logout_r, sp_power_r, drive_power_r, disk_read_r, load_own_r;
  wire         load_ip_r, load_sp2_r, init_dls_r, sections_power_r, remote_power_r;
  wire         ip_suspend_r, logout_req_r, mc_interrupt_r, parity_err_r, decode_err_r;
  wire         bus_req_r;
  wire [1:0]   disk_kind;
  wire [7:0]   disk_byte, disk_wdata_r;
  wire [15:0]  dev_grant_r;
  wire [3:0]   err_code_r;
  int          err_count = 0, compares = 0;
  spb_sequencer #(.SETTLE(4)) dut (.*);
  spb_disk_model #(.SERIAL(16'hA5C3)) partner (.clk(clk), .reset_n(reset_n),
    .drive_power_r(drive_power_r), .disk_read_r(disk_read_r), .bad_hash(bad_hash),
    .loading(load_own_r | load_ip_r | load_sp2_r), .drive_ready(drive_ready),
    .disk_valid(disk_valid), .disk_kind(disk_kind), .disk_byte(disk_byte));
  initial forever #4 clk = ~clk;
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task rst;
    reset_n = 0;
    cyc(8);
    reset_n = 1;
    cyc(2);
    chk("sp_power", 1, sp_power_r);
  endtask
  task press;
    load_button = 1;
    cyc(6);
    load_button = 0;
  endtask
  task wait_err(input logic [3:0] e);
    for (int k = 0; k < 3000 && err_code_r === 4'h0; k++) cyc(1);
    cyc(3);
    chk("err_code", e, err_code_r);
    chk("stopped", 0, load_ip_r | init_dls_r | done_r);
  endtask
  task boot_ok;
    int t[4];
    t = '{0, 0, 0, 0};
    rst;
    for (int k = 1; k < 3000 && done_r !== 1'b1; k++) begin
      cyc(1);
      if (load_own_r && t[0] == 0) t[0] = k;
      if (sections_power_r && t[1] == 0) t[1] = k;
      if (load_ip_r && t[2] == 0) t[2] = k;
      if (load_sp2_r && t[3] == 0) t[3] = k;
    end
    chk("done", 1, done_r);
    chk("order", 1, t[0] > 0 && t[0] < t[1] && t[1] < t[2] && t[2] < t[3]);
    chk("remote", 1, remote_power_r);
  endtask
  task rd(input logic p, input logic d);
    cs_parity = p;
    dec_check = d;
    cs_read = 1;
    cyc(1);
    cs_read = 0;
    cyc(4);
  endtask
  task grant(input logic [15:0] req, input logic [15:0] e);
    logic [15:0] g;
    g = 0;
    dev_req = req;
    repeat (40) begin
      bus_grant = bus_req_r;
      cyc(1);
      if (g === 16'h0) g = dev_grant_r;
    end
    dev_req = 0;
    // keep answering until the held grant is released, else it sticks
    repeat (4) begin
      bus_grant = bus_req_r;
      cyc(1);
    end
    bus_grant = 0;
    cyc(2);
    chk("grant", e, g);
    chk("bus_rel", 0, bus_req_r | dev_grant_r);
  endtask
  task patch_off;
    cs_word = 32'h5A;
    patch_req = 1;
    cyc(3);
    chk("patch_wr", 1, disk_write_r);
    chk("patch_data", 16'h005A, disk_wdata_r);
    chk("patch_busy", 1, busy_r);
    patch_req = 0;
    cyc(3);
    chk("patch_end", 0, disk_write_r | busy_r);
    chk("patch_run", 1, done_r);
    cs_word = 32'h1;
    poweroff_button = 1;
    cyc(6);
    poweroff_button = 0;
    cyc(2);
    chk("remote_off", 0, remote_power_r | sections_power_r);
  endtask
  task diag;
    logic early;
    for (int i = 0; i < 2; i++) begin
      machine_check = i == 0;
      channel_check = i == 1;
      for (int k = 0; k < 50 && logout_req_r !== 1'b1; k++) cyc(1);
      chk("suspend", 1, ip_suspend_r);
      logout_valid = 1;
      logout_last = 1;
      sp2_logout_valid = 1;
      cyc(1);
      chk("sp2_logout", 1, sp2_logout_r);
      sp2_logout_valid = 0;
      logout_valid = 0;
      logout_last = 0;
      machine_check = 0;
      channel_check = 0;
      early = 0;
      repeat (10) begin
        cyc(1);
        early |= mc_interrupt_r;
      end
      chk("early_int", 0, early);
      diag_done = 1;
      for (int k = 0; k < 50 && mc_interrupt_r !== 1'b1; k++) cyc(1);
      chk("mc_int", 1, mc_interrupt_r);
      diag_done = 0;
      cyc(4);
      chk("resume", 0, ip_suspend_r);
    end
  endtask
  task print_verdict;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    boot_ok;
    rd(1, 0);
    chk("par_ok", 0, parity_err_r | decode_err_r);
    rd(0, 0);
    chk("par_bad", 1, parity_err_r);
    rd(1, 1);
    chk("dec_bad", 1, decode_err_r);
    grant(16'h0408, 16'h0008);
    grant(16'h0400, 16'h0000);
    expansion_fitted = 1;
    grant(16'h0400, 16'h0400);
    diag;
    patch_off;
    bad_hash = 1;
    press;
    wait_err(4'h4);
    bad_hash = 0;
    machine_serial = 16'h5A3C;
    rst;
    wait_err(4'h3);
    machine_serial = 16'hA5C3;
    press;
    for (int k = 0; k < 3000 && done_r !== 1'b1; k++) cyc(1);
    chk("reload", 1, done_r);
    for (int i = 0; i < 4; i++) begin
      okv = ~(4'h1 << i);
      rst;
      wait_err(i < 2 ? 4'(i + 1) : 4'(i + 3));
    end
    print_verdict;
  end
  initial begin
    #400us;
    err_count++;
    print_verdict;
  end
endmodule
